// File: verilog/scac_consts.svh
// Constants of the split cache and access control block.
`ifndef SCAC_CONSTS_SVH
`define SCAC_CONSTS_SVH
`define SCAC_CCR_OFF       8'h00
`define SCAC_CAR_OFF       8'h04
`define SCAC_AC0_OFF       8'h08
`define SCAC_AC1_OFF       8'h0c
`define SCAC_ASR_OFF       8'h10
`define SCAC_CCR_RST       32'h0000_0000
`define SCAC_CCR_RMASK     32'h0000_3313
`define SCAC_ACR_RST       32'h0000_0000
`define SCAC_ACR_WMASK     32'hff7f_a377
`define SCAC_I_EN          0
`define SCAC_I_FRZ         1
`define SCAC_I_CLRE        2
`define SCAC_I_CLR         3
`define SCAC_I_BRST        4
`define SCAC_D_EN          8
`define SCAC_D_FRZ         9
`define SCAC_D_CLRE        10
`define SCAC_D_CLR         11
`define SCAC_D_BRST        12
`define SCAC_D_WA          13
`define SCAC_ACR_BASE_HI   31
`define SCAC_ACR_BASE_LO   24
`define SCAC_ACR_MASK_HI   23
`define SCAC_ACR_MASK_LO   16
`define SCAC_ACR_EN        15
`define SCAC_ACR_CI        13
`define SCAC_ACR_RW        9
`define SCAC_ACR_RWM       8
`define SCAC_ACR_FCB_HI    6
`define SCAC_ACR_FCB_LO    4
`define SCAC_ACR_FCM_HI    2
`define SCAC_ACR_FCM_LO    0
`define SCAC_FC_PROG       2'b10
`define SCAC_WORDS         64
`define SCAC_LINES         16
`define SCAC_LINE_WORDS    4
`define SCAC_IDX_HI        7
`define SCAC_WORD_HI       3
`define SCAC_WORD_LO       2
`define SCAC_LINE_LO       4
`define SCAC_TAG_LO        8
`define SCAC_SYNC_MIN_CLK  2'd2
`define SCAC_ASYNC_MIN_CLK 2'd3
`define SCAC_CNT_MAX       2'd3
`define SCAC_LAST_BEAT     2'd3
`endif

// File: verilog/scac_pkg.sv
// Types shared by the split cache and access control block.
package scac_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_FIRST = 2'b01,
    BUS_BURST = 2'b11,
    BUS_END   = 2'b10
  } scac_bus_type;
endpackage

// File: verilog/scac_cache.sv
// Direct-mapped 64-word cache array with a valid bit per long word.
`timescale 1ns/1ps
`include "scac_consts.svh"
module scac_cache
  import scac_pkg::*;
(
  input  wire logic        hclk,     // Processor clock.
  input  wire logic        hresetn,  // Asynchronous reset, active low.
  input  wire logic [31:0] lk_addr,  // Lookup address.
  output logic             lk_hit,   // Looked-up word is present.
  output logic      [31:0] lk_data,  // Looked-up word.
  input  wire logic        wr_en,    // Write one word.
  input  wire logic        wr_new,   // Write opens a new line.
  input  wire logic [31:0] wr_addr,  // Write address.
  input  wire logic [31:0] wr_data,  // Write data.
  input  wire logic        inv_all,  // Invalidate every entry.
  input  wire logic        inv_line, // Invalidate one line.
  input  wire logic [31:0] inv_addr  // Address of the line to invalidate.
);
  logic [31:0]                      data_mem [`SCAC_WORDS];
  logic [31:`SCAC_TAG_LO]           tag_mem  [`SCAC_LINES];
  logic [`SCAC_WORDS-1:0]           valid_q;

  // Lookup is combinational so a hit answers in the same cycle.
  assign lk_hit  = valid_q[lk_addr[`SCAC_IDX_HI:`SCAC_WORD_LO]]
    && (tag_mem[lk_addr[`SCAC_IDX_HI:`SCAC_LINE_LO]]
        == lk_addr[31:`SCAC_TAG_LO]);
  assign lk_data = data_mem[lk_addr[`SCAC_IDX_HI:`SCAC_WORD_LO]];

  // Storage carries no reset; the valid bits alone guard it.
  always_ff @(posedge hclk) begin
    if (wr_en) begin
      data_mem[wr_addr[`SCAC_IDX_HI:`SCAC_WORD_LO]] <= wr_data;
      if (wr_new) begin
        tag_mem[wr_addr[`SCAC_IDX_HI:`SCAC_LINE_LO]] <=
          wr_addr[31:`SCAC_TAG_LO];
      end
    end
  end

  // A new line drops its other words, so a partial fill hits only loaded
  // words; a write in the same cycle as an invalidate still lands.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      valid_q <= '0;
    end else begin
      if (inv_all) begin
        valid_q <= '0;
      end else if (inv_line) begin
        valid_q[{inv_addr[`SCAC_IDX_HI:`SCAC_LINE_LO], 2'b00}
                +: `SCAC_LINE_WORDS] <= '0;
      end
      if (wr_en && wr_new) begin
        valid_q[{wr_addr[`SCAC_IDX_HI:`SCAC_LINE_LO], 2'b00}
                +: `SCAC_LINE_WORDS] <= '0;
      end
      if (wr_en) begin
        valid_q[wr_addr[`SCAC_IDX_HI:`SCAC_WORD_LO]] <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_INV_ALL: assert property (inv_all && !wr_en |=> !lk_hit)
    else $error("Entry still hits after a full invalidate.");
  AST_FILL_HIT: assert property ((wr_en && !inv_all) ##1
    (lk_addr[31:2] == $past(wr_addr[31:2]))
    |-> lk_hit && lk_data == $past(wr_data))
    else $error("Freshly written word does not hit.");
endmodule

// File: verilog/scac_top.sv
// Split caches, access control unit and burst bus unit of the controller.
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "scac_consts.svh"
// Behaviour
// - Each cache holds 64 long words filled by the bus unit.
// - Entries form lines of four long words under one tag.
// - Data writes always go to memory; write miss allocation is set by sw.
// - Each cache has its own address and data path, usable in one cycle.
// - A fill asks for a burst of up to four words that prefill the line.
// - Async cycles take 3+ clocks, sync 2+, each further burst beat 1.
// - Two access control registers each define a 16 MB to 2 GB segment.
// - A segment matches on address, read or write, and function code.
// - Accesses in a noncacheable segment bypass both caches.
// - Access control registers are reachable in supervisor state only.
// - A status register keeps the result of the latest segment probe.
// - A cache control register gives sw control and status of caches.
// - Cache operations needing an address take it from a target register.
// - Function code outputs name the access space in every bus cycle.
module scac_top
  import scac_pkg::*;
(
  input  wire logic        hclk,          // Processor clock, 50 MHz.
  input  wire logic        hresetn,       // Asynchronous reset, low.
  input  wire logic        hsel,          // AHB slave select.
  input  wire logic [31:0] haddr,         // AHB address.
  input  wire logic [1:0]  htrans,        // AHB transfer type.
  input  wire logic        hwrite,        // AHB write.
  input  wire logic [2:0]  hsize,         // AHB size, word only.
  input  wire logic [3:0]  hprot,         // AHB protection, bit 1 priv.
  input  wire logic [31:0] hwdata,        // AHB write data.
  input  wire logic        hready,        // AHB bus ready.
  output logic             hreadyout,     // AHB slave ready.
  output logic             hresp,         // AHB response.
  output logic      [31:0] hrdata,        // AHB read data.
  input  wire logic        i_req,         // Instruction fetch request.
  input  wire logic [31:0] i_addr,        // Fetch address.
  input  wire logic        i_super,       // Fetch in supervisor state.
  output logic             i_ack,         // Fetch answered, pulse.
  output logic      [31:0] i_rdata,       // Fetched word.
  input  wire logic        d_req,         // Data access request.
  input  wire logic        d_we,          // Data access is a write.
  input  wire logic [31:0] d_addr,        // Data address.
  input  wire logic [31:0] d_wdata,       // Data to write.
  input  wire logic [2:0]  d_fc,          // Data function code.
  output logic             d_ack,         // Data access done, pulse.
  output logic      [31:0] d_rdata,       // Data read word.
  input  wire logic        probe_req,     // Segment probe, pulse.
  input  wire logic [31:0] probe_addr,    // Probe address.
  input  wire logic        probe_rd,      // Probe direction, 1 read.
  input  wire logic [2:0]  probe_fc,      // Probe function code.
  output logic             mem_as,        // Bus cycle strobe.
  output logic      [31:0] mem_addr,      // Bus address.
  output logic             mem_we,        // Bus cycle writes.
  output logic      [31:0] mem_wdata,     // Bus write data.
  output logic      [2:0]  mem_fc,        // Function code outputs.
  output logic             mem_burst_req, // Burst requested.
  input  wire logic        mem_sack,      // Synchronous acknowledge.
  input  wire logic        mem_aack,      // Asynchronous acknowledge.
  input  wire logic        mem_burst_ack, // Memory grants the burst.
  input  wire logic [31:0] mem_rdata      // Bus read data.
);
  scac_bus_type bus_q;
  logic [1:0]  bcnt_q, beat_q;
  logic        bsrc_q, bfill_q, i_pend_q, d_pend_q;
  logic        hrdy_q, wr_ph_q, priv_q;
  logic [7:0]  wa_q;
  logic [31:0] ccr_q, car_q, acr0_q, acr1_q, asr_q, rd_d;
  logic        i_nc, d_nc, i_hit_ok, d_hit_ok, i_go, d_go, i_fill, d_fill;
  logic        done1, beat_done, go_burst, dwt_wr, ccr_wr;
  logic        ic_hit, dc_hit, ic_wr, dc_wr_en, dc_wr_new;
  logic [31:0] ic_data, dc_data, dc_wr_addr, dc_wr_data;
  logic [2:0]  i_fc;
  logic [3:0]  inv_q;

  // A segment of 2^(24+n) bytes: mask bit 7 is never writable, so the
  // largest segment is 2 GB.
  function automatic logic acr_match(input logic [31:0] acr,
    input logic [31:0] a, input logic rd, input logic [2:0] fc);
    logic [7:0] m;
    m = acr[`SCAC_ACR_MASK_HI:`SCAC_ACR_MASK_LO];
    return acr[`SCAC_ACR_EN]
      && (((a[`SCAC_ACR_BASE_HI:`SCAC_ACR_BASE_LO]
           ^ acr[`SCAC_ACR_BASE_HI:`SCAC_ACR_BASE_LO]) & ~m) == 8'h00)
      && (acr[`SCAC_ACR_RWM] || (rd == acr[`SCAC_ACR_RW]))
      && (((fc ^ acr[`SCAC_ACR_FCB_HI:`SCAC_ACR_FCB_LO])
           & ~acr[`SCAC_ACR_FCM_HI:`SCAC_ACR_FCM_LO]) == 3'h0);
  endfunction

  // Either segment marked cache inhibit makes the access noncacheable.
  function automatic logic non_cache(input logic [31:0] a,
    input logic rd, input logic [2:0] fc);
    return (acr_match(acr0_q, a, rd, fc) && acr0_q[`SCAC_ACR_CI])
      || (acr_match(acr1_q, a, rd, fc) && acr1_q[`SCAC_ACR_CI]);
  endfunction

  // Two arrays with separate ports, so both sides can hit together.
  scac_cache u_icache (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .lk_addr  (i_addr),
    .lk_hit   (ic_hit),
    .lk_data  (ic_data),
    .wr_en    (ic_wr),
    .wr_new   (bus_q == BUS_FIRST),
    .wr_addr  (mem_addr),
    .wr_data  (mem_rdata),
    .inv_all  (inv_q[0]),
    .inv_line (inv_q[1]),
    .inv_addr (car_q)
  );
  scac_cache u_dcache (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .lk_addr  (d_addr),
    .lk_hit   (dc_hit),
    .lk_data  (dc_data),
    .wr_en    (dc_wr_en),
    .wr_new   (dc_wr_new),
    .wr_addr  (dc_wr_addr),
    .wr_data  (dc_wr_data),
    .inv_all  (inv_q[2]),
    .inv_line (inv_q[3]),
    .inv_addr (car_q)
  );

  // Request steering; data takes the bus before instruction fetches.
  always_comb begin
    i_fc      = {i_super, `SCAC_FC_PROG};
    i_nc      = non_cache(i_addr, 1'b1, i_fc);
    d_nc      = non_cache(d_addr, !d_we, d_fc);
    i_hit_ok  = i_req && !i_ack && !i_pend_q && ccr_q[`SCAC_I_EN]
      && !i_nc && ic_hit;
    d_hit_ok  = d_req && !d_ack && !d_pend_q && !d_we
      && ccr_q[`SCAC_D_EN] && !d_nc && dc_hit;
    d_go      = d_req && !d_ack && !d_pend_q && !d_hit_ok;
    i_go      = i_req && !i_ack && !i_pend_q && !i_hit_ok && !d_go;
    i_fill    = !i_nc && ccr_q[`SCAC_I_EN];
    d_fill    = !d_we && !d_nc && ccr_q[`SCAC_D_EN];
    done1     = (bus_q == BUS_FIRST)
      && ((mem_sack && bcnt_q >= `SCAC_SYNC_MIN_CLK - 2'd1)
       || (mem_aack && bcnt_q >= `SCAC_ASYNC_MIN_CLK - 2'd1));
    beat_done = done1 || (bus_q == BUS_BURST && mem_sack);
    go_burst  = bfill_q && mem_burst_req && mem_burst_ack;
    dwt_wr    = bus_q == BUS_IDLE && d_go && d_we && !d_nc
      && ccr_q[`SCAC_D_EN]
      && (dc_hit || (ccr_q[`SCAC_D_WA] && !ccr_q[`SCAC_D_FRZ]));
  end

  // Cache write ports: fills from the bus, or a write-through update.
  always_comb begin
    ic_wr      = beat_done && bfill_q && !bsrc_q
      && !ccr_q[`SCAC_I_FRZ];
    dc_wr_en   = dwt_wr || (beat_done && bfill_q && bsrc_q
      && !ccr_q[`SCAC_D_FRZ]);
    dc_wr_new  = dwt_wr ? !dc_hit : (bus_q == BUS_FIRST);
    dc_wr_addr = dwt_wr ? d_addr : mem_addr;
    dc_wr_data = dwt_wr ? d_wdata : mem_rdata;
  end

  // Bus cycle sequencer; END keeps the strobe low between cycles.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_q   <= BUS_IDLE;
      bcnt_q  <= 2'h0;
      beat_q  <= 2'h0;
      bsrc_q  <= 1'b0;
      bfill_q <= 1'b0;
    end else begin
      case (bus_q)
        BUS_IDLE: begin
          if (d_go || i_go) begin
            bus_q   <= BUS_FIRST;
            bcnt_q  <= 2'h0;
            bsrc_q  <= d_go;
            bfill_q <= d_go ? d_fill : i_fill;
          end
        end
        BUS_FIRST: begin
          if (bcnt_q != `SCAC_CNT_MAX) begin
            bcnt_q <= bcnt_q + 2'h1;
          end
          if (done1) begin
            bus_q  <= go_burst ? BUS_BURST : BUS_END;
            beat_q <= 2'h1;
          end
        end
        BUS_BURST: begin
          if (mem_sack) begin
            beat_q <= beat_q + 2'h1;
            if (beat_q == `SCAC_LAST_BEAT) begin
              bus_q <= BUS_END;
            end
          end
        end
        default: begin
          bus_q <= BUS_IDLE;
        end
      endcase
    end
  end

  // Bus pins; the word address wraps inside the line during a burst.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_as        <= 1'b0;
      mem_addr      <= 32'h0000_0000;
      mem_we        <= 1'b0;
      mem_wdata     <= 32'h0000_0000;
      mem_fc        <= 3'h0;
      mem_burst_req <= 1'b0;
    end else begin
      if (bus_q == BUS_IDLE && (d_go || i_go)) begin
        mem_as        <= 1'b1;
        mem_addr      <= {(d_go ? d_addr[31:`SCAC_WORD_LO]
                               : i_addr[31:`SCAC_WORD_LO]), 2'b00};
        mem_we        <= d_go && d_we;
        mem_wdata     <= d_wdata;
        mem_fc        <= d_go ? d_fc : i_fc;
        mem_burst_req <= d_go ? (d_fill && ccr_q[`SCAC_D_BRST])
                              : (i_fill && ccr_q[`SCAC_I_BRST]);
      end else if (beat_done) begin
        mem_addr[`SCAC_WORD_HI:`SCAC_WORD_LO] <=
          mem_addr[`SCAC_WORD_HI:`SCAC_WORD_LO] + 2'h1;
        if (done1 ? !go_burst : beat_q == `SCAC_LAST_BEAT) begin
          mem_as        <= 1'b0;
          mem_burst_req <= 1'b0;
        end
      end
    end
  end

  // Core answers: a hit answers the next cycle, a miss at its first beat.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      i_ack    <= 1'b0;
      i_rdata  <= 32'h0000_0000;
      d_ack    <= 1'b0;
      d_rdata  <= 32'h0000_0000;
      i_pend_q <= 1'b0;
      d_pend_q <= 1'b0;
    end else begin
      i_ack   <= i_hit_ok || (done1 && !bsrc_q);
      i_rdata <= i_hit_ok ? ic_data : mem_rdata;
      d_ack   <= d_hit_ok || (done1 && bsrc_q);
      d_rdata <= d_hit_ok ? dc_data : mem_rdata;
      if (bus_q == BUS_IDLE && i_go) begin
        i_pend_q <= 1'b1;
      end else if (done1 && !bsrc_q) begin
        i_pend_q <= 1'b0;
      end
      if (bus_q == BUS_IDLE && d_go) begin
        d_pend_q <= 1'b1;
      end else if (done1 && bsrc_q) begin
        d_pend_q <= 1'b0;
      end
    end
  end

  // AHB-Lite slave with no wait states; data phase is one cycle.
  assign hresp = 1'b0;
  assign hreadyout = hrdy_q;
  assign ccr_wr = wr_ph_q && priv_q && wa_q == `SCAC_CCR_OFF;
  always_comb begin
    if (haddr[7:0] == `SCAC_CCR_OFF) begin
      rd_d = ccr_q;
    end else if (haddr[7:0] == `SCAC_CAR_OFF) begin
      rd_d = car_q;
    end else if (haddr[7:0] == `SCAC_AC0_OFF) begin
      rd_d = acr0_q;
    end else if (haddr[7:0] == `SCAC_AC1_OFF) begin
      rd_d = acr1_q;
    end else if (haddr[7:0] == `SCAC_ASR_OFF) begin
      rd_d = asr_q;
    end else begin
      rd_d = 32'h0000_0000;
    end
  end

  // Address phase capture; a user-mode access reads zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdy_q  <= 1'b0;
      wr_ph_q <= 1'b0;
      priv_q  <= 1'b0;
      wa_q    <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else begin
      hrdy_q  <= 1'b1;
      wr_ph_q <= hsel && htrans[1] && hready && hwrite;
      priv_q  <= hprot[1];
      wa_q    <= haddr[7:0];
      hrdata  <= (hsel && htrans[1] && hready && !hwrite && hprot[1])
                 ? rd_d : 32'h0000_0000;
    end
  end

  // Register writes in the data phase, privileged only.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ccr_q  <= `SCAC_CCR_RST;
      car_q  <= 32'h0000_0000;
      acr0_q <= `SCAC_ACR_RST;
      acr1_q <= `SCAC_ACR_RST;
    end else if (wr_ph_q && priv_q) begin
      if (wa_q == `SCAC_CCR_OFF) begin
        ccr_q <= hwdata & `SCAC_CCR_RMASK;
      end else if (wa_q == `SCAC_CAR_OFF) begin
        car_q <= hwdata;
      end else if (wa_q == `SCAC_AC0_OFF) begin
        acr0_q <= hwdata & `SCAC_ACR_WMASK;
      end else if (wa_q == `SCAC_AC1_OFF) begin
        acr1_q <= hwdata & `SCAC_ACR_WMASK;
      end
    end
  end

  // Clear commands are one-cycle pulses that never read back.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inv_q <= 4'h0;
    end else begin
      inv_q <= {ccr_wr && hwdata[`SCAC_D_CLRE],
                ccr_wr && hwdata[`SCAC_D_CLR],
                ccr_wr && hwdata[`SCAC_I_CLRE],
                ccr_wr && hwdata[`SCAC_I_CLR]};
    end
  end

  // Probe result: bit 0 any match, bits 1 and 2 each segment.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      asr_q <= 32'h0000_0000;
    end else if (probe_req) begin
      asr_q <= {29'h0,
        acr_match(acr1_q, probe_addr, probe_rd, probe_fc),
        acr_match(acr0_q, probe_addr, probe_rd, probe_fc),
        acr_match(acr0_q, probe_addr, probe_rd, probe_fc)
        || acr_match(acr1_q, probe_addr, probe_rd, probe_fc)};
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_wt_start;
    bus_q == BUS_IDLE && d_go && d_we;
  endsequence
  sequence s_wt_issue;
    mem_as && mem_we && mem_wdata == $past(d_wdata);
  endsequence

  AST_SYNC_MIN: assert property (bus_q == BUS_FIRST && mem_sack
    && !$past(mem_as) |=> bus_q == BUS_FIRST)
    else $error("Synchronous cycle ended in under two clocks.");
  AST_ASYNC_MIN: assert property (bus_q == BUS_FIRST && mem_aack
    && !mem_sack && !$past(mem_as, 2) |=> bus_q == BUS_FIRST)
    else $error("Asynchronous cycle ended in under three clocks.");
  AST_BURST_BEAT: assert property (bus_q == BUS_BURST && mem_sack
    |=> mem_addr[3:2] == $past(mem_addr[3:2]) + 2'h1)
    else $error("Burst beat did not complete in one clock.");
  AST_BURST_MAX: assert property (bus_q == BUS_BURST && mem_sack
    && beat_q == 2'd3 |=> !mem_as ##1 bus_q == BUS_IDLE)
    else $error("Burst ran past four long words.");
  AST_WT: assert property (s_wt_start |=> s_wt_issue)
    else $error("Data write was not passed to memory.");
  AST_WR_HIT: assert property (s_wt_start ##0 dc_hit && !d_nc
    && ccr_q[`SCAC_D_EN] |-> dc_wr_en && dc_wr_data == d_wdata)
    else $error("Write hit did not update the cached word.");
  AST_NC: assert property (beat_done && !bfill_q
    |-> !ic_wr && !dc_wr_en && !mem_burst_req)
    else $error("Noncacheable access touched a cache.");
  AST_PRIV: assert property (wr_ph_q && !priv_q |=> $stable(ccr_q)
    && $stable(acr0_q) && $stable(acr1_q))
    else $error("User-mode write changed a control register.");
  AST_PROBE: assert property (probe_req |=> asr_q[0] == $past(
    acr_match(acr0_q, probe_addr, probe_rd, probe_fc)
    || acr_match(acr1_q, probe_addr, probe_rd, probe_fc)))
    else $error("Probe result not recorded.");
  AST_SEG: assert property (acr0_q[23] == 1'b0 && acr1_q[23] == 1'b0)
    else $error("Segment wider than 2 GB.");
  AST_FC: assert property (mem_as && $past(mem_as) |-> $stable(mem_fc))
    else $error("Function code moved inside a bus cycle.");
  AST_PAR: assert property (i_hit_ok && d_hit_ok |=> i_ack && d_ack)
    else $error("Parallel hits were not served together.");
endmodule

// File: sim/scac_mem_model.sv
// Burst-capable memory model that answers the controller's bus cycles.
`timescale 1ns/1ps
module scac_mem_model (
  input  wire logic        hclk,          // Processor clock.
  input  wire logic        hresetn,       // Reset, active low.
  input  wire logic        mem_as,        // Cycle strobe.
  input  wire logic [31:0] mem_addr,      // Cycle address.
  input  wire logic        mem_burst_req, // Burst asked for.
  input  wire logic [3:0]  wt,            // Strobe clocks up to the ack.
  input  wire logic        asyn,          // Answer the first beat async.
  input  wire logic        bok,           // Grant bursts.
  output logic             mem_sack,      // Synchronous ack.
  output logic             mem_aack,      // Asynchronous ack.
  output logic             mem_burst_ack, // Burst granted.
  output logic      [31:0] mem_rdata      // Read data.
);
  logic [3:0] cnt_q;
  logic [2:0] nb_q;
  logic       ack_q;
  logic [2:0] need;
  assign need = (mem_burst_req && bok) ? 3'd4 : 3'd1;
  // Acks wait out the strobe time, so a slow memory is modelled too.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn || !mem_as) begin
      cnt_q <= 4'h0;
      nb_q  <= 3'd0;
      ack_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      nb_q  <= nb_q + {2'b00, ack_q};
      ack_q <= (cnt_q + 4'h2 >= wt) && (nb_q + {2'b00, ack_q} < need);
    end
  end
  assign mem_sack      = ack_q && !(asyn && nb_q == 3'd0);
  assign mem_aack      = ack_q && asyn && nb_q == 3'd0;
  assign mem_burst_ack = ack_q && bok && nb_q == 3'd0;
  // Between beats the lines toggle, so a stale word never passes.
  assign mem_rdata = ack_q ? {mem_addr[31:2], 2'b00} ^ 32'h0f0f_0000
                           : {32{cnt_q[0]}} ^ 32'h3c3c_5a5a;
endmodule

// File: sim/tb.sv
// Self-checking bench of the split cache and access control block.
`timescale 1ns/1ps
module tb;
  logic        hclk, hresetn, hsel, hwrite, i_req, i_super, d_req, d_we;
  logic        probe_req, probe_rd, asyn, bok, hreadyout, hresp, i_ack;
  logic        d_ack, mem_as, mem_we, mem_burst_req, mem_sack, mem_aack;
  logic        mem_burst_ack, wev;
  logic [1:0]  htrans;
  logic [3:0]  hprot, wt;
  logic [2:0]  d_fc, probe_fc, mem_fc, fcv;
  logic [31:0] haddr, hwdata, i_addr, d_addr, d_wdata, probe_addr, hrdata;
  logic [31:0] i_rdata, d_rdata, mem_addr, mem_wdata, mem_rdata, rv, wdv;
  int          n_fail, total_checks, cyc, nb;
  // Rows: offset, write privilege, read privilege, written, read back.
  logic [73:0] rows [6] = '{{8'h00, 2'b11, 32'hffff_ffff, 32'h0000_3313},
    {8'h08, 2'b11, 32'hffff_ffff, 32'hff7f_a377},
    {8'h0c, 2'b01, 32'h1234_5678, 32'h0000_0000},
    {8'h08, 2'b10, 32'hffff_ffff, 32'h0000_0000},
    {8'h10, 2'b11, 32'hffff_ffff, 32'h0000_0000},
    {8'h14, 2'b11, 32'hffff_ffff, 32'h0000_0000}};
  scac_top scac_top_inst (.hsize(3'b010), .hready(hreadyout), .*);
  scac_mem_model scac_mem_model_inst (.*);
  // Free-running clock.
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // Cycle ceiling; a hang counts as a mismatch.
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      conclude();
    end
  end
  // Record each bus beat as the memory takes it.
  always @(posedge hclk) if (mem_as && (mem_sack || mem_aack)) begin
    nb++;
    fcv = mem_fc;
    wev = mem_we;
    wdv = mem_wdata;
  end
  function automatic logic [31:0] f(input logic [31:0] a);
    return {a[31:2], 2'b00} ^ 32'h0f0f_0000;
  endfunction
  task conclude();
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Wide enough for the packed checks, so no field is cut away.
  task chk(input logic [95:0] got, input logic [95:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rst();
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  // One AHB single transfer; the data phase ends on hready high.
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
           input logic pr);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
    hprot <= {2'b00, pr, 1'b1};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task dacc(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    {d_req, d_we, d_addr, d_wdata, d_fc} <= {1'b1, w, a, wd, 3'd5};
    do @(posedge hclk); while (d_ack !== 1'b1);
    rv = d_rdata;
    d_req <= 1'b0;
    // Let a running burst finish, so the beat count is final.
    while (mem_as) @(posedge hclk);
  endtask
  task iacc(input logic [31:0] a);
    @(posedge hclk);
    {i_req, i_addr, i_super} <= {1'b1, a, 1'b1};
    do @(posedge hclk); while (i_ack !== 1'b1);
    chk(i_rdata, f(a));
    i_req <= 1'b0;
    while (mem_as) @(posedge hclk);
  endtask
  task probe(input logic [31:0] a, input logic [31:0] exp);
    @(posedge hclk);
    {probe_req, probe_addr, probe_rd, probe_fc} <= {1'b1, a, 1'b1, 3'd5};
    @(posedge hclk);
    probe_req <= 1'b0;
    ahb(1'b0, 8'h10, 32'h0, 1'b1);
    chk(rv, exp);
  endtask
  initial begin
    {hsel, hwrite, i_req, i_super, d_req, d_we, probe_req, probe_rd} = 8'h00;
    {htrans, hprot, d_fc, probe_fc, asyn, bok, wt} = {13'h0, 1'b1, 4'd2};
    {haddr, hwdata, i_addr, d_addr, d_wdata, probe_addr} = '0;
    hresetn = 1'b0;
    rst();
    for (int a = 0; a < 20; a += 4) begin
      ahb(1'b0, 8'(a), 32'h0, 1'b1);
      chk(rv, 32'h0);
    end
    foreach (rows[k]) begin
      ahb(1'b1, rows[k][73:66], rows[k][63:32], rows[k][65]);
      ahb(1'b0, rows[k][73:66], 32'h0, rows[k][64]);
      chk(rv, rows[k][31:0]);
    end
    ahb(1'b1, 8'h00, 32'h0000_1111, 1'b1);
    ahb(1'b1, 8'h08, 32'h0, 1'b1);
    nb = 0;
    dacc(1'b0, 32'h100, 32'h0);
    chk(rv, f(32'h100));
    chk({nb, fcv}, {32'd4, 3'd5});
    dacc(1'b0, 32'h10c, 32'h0);
    chk({rv, nb}, {f(32'h10c), 32'd4});
    iacc(32'h200);
    chk(fcv, 3'd6);
    fork
      iacc(32'h200);
      dacc(1'b0, 32'h104, 32'h0);
    join
    chk({rv, nb}, {f(32'h104), 32'd8});
    dacc(1'b1, 32'h104, 32'hdead_beef);
    chk({wev, wdv, nb}, {1'b1, 32'hdead_beef, 32'd9});
    dacc(1'b0, 32'h104, 32'h0);
    chk({rv, nb}, {32'hdead_beef, 32'd9});
    dacc(1'b1, 32'h304, 32'h5);
    dacc(1'b0, 32'h304, 32'h0);
    chk({rv, nb}, {f(32'h304), 32'd14});
    ahb(1'b1, 8'h00, 32'h0000_3111, 1'b1);
    dacc(1'b1, 32'h404, 32'h1111_2222);
    dacc(1'b0, 32'h404, 32'h0);
    chk({rv, nb}, {32'h1111_2222, 32'd15});
    ahb(1'b1, 8'h08, 32'h007f_a107, 1'b1);
    dacc(1'b0, 32'h100, 32'h0);
    chk({rv, nb}, {f(32'h100), 32'd16});
    probe(32'h100, 32'h3);
    probe(32'h8000_0000, 32'h0);
    {asyn, wt} <= {1'b1, 4'd3};
    dacc(1'b0, 32'h500, 32'h0);
    chk({rv, nb}, {f(32'h500), 32'd17});
    asyn <= 1'b0;
    ahb(1'b1, 8'h08, 32'h0, 1'b1);
    ahb(1'b1, 8'h04, 32'h100, 1'b1);
    ahb(1'b1, 8'h00, 32'h0000_3511, 1'b1);
    dacc(1'b0, 32'h104, 32'h0);
    chk({rv, nb}, {f(32'h104), 32'd21});
    rst();
    ahb(1'b0, 8'h00, 32'h0, 1'b1);
    chk(rv, 32'h0);
    conclude();
  end
endmodule
